// ### rtl/phy_config_media_fields.sv
// Purpose: config and media status register upper fields, apb slave
// Assumes: eeprom loader pulses ee_load_valid once after power-up
// Notes: zero wait state slave, pslverr on unmapped address
`timescale 1ns/10ps
`include "phy_cfg_defs.svh"
module phy_config_media_fields
  import phy_cfg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phy_aneg_complete,
  input  wire logic        phy_irq_event,
  input  wire logic        phy_reg_access,
  input  wire logic        ee_load_valid,
  input  wire logic        ee_pause,
  input  wire logic [2:0]  ee_select,
  output logic             phy_irq_pending,
  output logic             phy_reset,
  output logic             phy_low_power,
  output logic             mii_enable,
  output phy_mode_s        phy_mode
);
  logic [31:0] cfg;
  logic        aneg_s1;
  logic        aneg_s2;
  logic        done_flag;
  phy_mode_s   next_mode;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  wire access   = psel & penable;
  wire wr_cfg   = access & pwrite & hit(paddr, `CFG_OFFSET);
  wire rd_isr   = access & ~pwrite & hit(paddr, `ISR_OFFSET);
  wire autoclr  = cfg[`BIT_AUTOCLR];
  wire external_phy_select  = cfg[`BIT_EXTPHY];
  wire internal_phy_disable  = cfg[`BIT_PHYDIS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aneg_s1 <= 1'b0;
      aneg_s2 <= 1'b0;
    end else begin
      aneg_s1 <= phy_aneg_complete;
      aneg_s2 <= aneg_s1;
    end
  end

  // done also when negotiation is not running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) done_flag <= 1'b0;
    else          done_flag <= aneg_s2 | ~next_mode.aneg_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= `CFG_RESET;
    end else begin
      if (wr_cfg) begin
        cfg <= pwdata & `CFG_WMASK;
        if (pwdata[`BIT_EXTPHY]) cfg[`BIT_PHYDIS] <= 1'b1;
      end
      // eeprom load wins for its fields: it runs only once at power-up
      if (ee_load_valid) begin
        cfg[`BIT_PAUSE] <= ee_pause;
        cfg[`FLD_SEL_HI:`FLD_SEL_LO] <= ee_select;
      end
    end
  end

  // event wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phy_irq_pending <= 1'b0;
    else if (phy_irq_event) phy_irq_pending <= 1'b1;
    else if (rd_isr && autoclr) phy_irq_pending <= 1'b0;
    else if (phy_reg_access) phy_irq_pending <= 1'b0;
  end

  aneg_decode u_dec (
    .autoneg_select  (cfg[`FLD_SEL_HI:`FLD_SEL_LO]),
    .pause_advertise (cfg[`BIT_PAUSE]),
    .mode            (next_mode)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_mode      <= '0;
      phy_reset     <= 1'b0;
      phy_low_power <= 1'b0;
      mii_enable    <= 1'b0;
    end else begin
      phy_mode      <= next_mode;
      phy_reset     <= cfg[`BIT_PHYRST];
      phy_low_power <= internal_phy_disable;
      mii_enable    <= external_phy_select;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (hit(paddr, `CFG_OFFSET)) begin
          prdata <= cfg;
          prdata[`BIT_ANEG_DONE] <= done_flag;
        end else if (!hit(paddr, `ISR_OFFSET)) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  chk_irq_autoclr: assert property (@(posedge pclk) disable iff (!presetn)
    rd_isr && autoclr && !phy_irq_event |=> !phy_irq_pending)
    else $error("autoclear read left irq pending");
  chk_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
    phy_irq_pending && !phy_reg_access && !(rd_isr && autoclr) |=> phy_irq_pending)
    else $error("irq dropped without clear");
  chk_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
    phy_irq_event |=> phy_irq_pending)
    else $error("irq event lost");
  chk_extphy_dis: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg && pwdata[`BIT_EXTPHY] |=> ##1 phy_low_power && mii_enable)
    else $error("external phy did not disable internal phy");
  chk_low_power: assert property (@(posedge pclk) disable iff (!presetn)
    internal_phy_disable |=> phy_low_power)
    else $error("phy disable not followed");
  chk_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    cfg[`BIT_PHYRST] && !wr_cfg |=> cfg[`BIT_PHYRST])
    else $error("phy reset self cleared");
  chk_ee_load: assert property (@(posedge pclk) disable iff (!presetn)
    ee_load_valid |=> cfg[`FLD_SEL_HI:`FLD_SEL_LO] == $past(ee_select)
                      && cfg[`BIT_PAUSE] == $past(ee_pause))
    else $error("eeprom load not stored");
  chk_pause_gate: assert property (@(posedge pclk) disable iff (!presetn)
    phy_mode.adv_pause |-> phy_mode.adv_modes[1] || phy_mode.adv_modes[3])
    else $error("pause advertised without full duplex");
  chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[26:24] == 3'h0 && prdata[11] == 1'b0 && prdata[8:0] == 9'h000)
    else $error("unused bits read nonzero");
  chk_done_off: assert property (@(posedge pclk) disable iff (!presetn)
    !next_mode.aneg_enable |=> done_flag)
    else $error("done low with negotiation off");
  chk_force_dec: assert property (@(posedge pclk) disable iff (!presetn)
    !next_mode.aneg_enable |-> next_mode.adv_modes == 4'h0)
    else $error("forced mode advertises");
  chk_adv_dec: assert property (@(posedge pclk) disable iff (!presetn)
    cfg[15:13] == 3'h7 |-> next_mode.adv_modes == 4'hF)
    else $error("select 111 wrong");
  chk_phycfg_rw: assert property (@(posedge pclk) disable iff (!presetn)
    wr_cfg |=> cfg[23:18] == $past(pwdata[23:18]))
    else $error("phy cfg not stored");
endmodule

// ### rtl/phy_cfg_defs.svh
// Purpose: constants for the phy configuration and media status register
// Assumes: APB byte addressing, one 32-bit word per register
// Notes: pause and select fields take their power-up values from the eeprom loader
// Notes on behaviour
// - done flag reads high when negotiation finished or negotiation is off
// - bits 23-18 hold six phy power-on configuration bits
// - autoclear enable set: a status register read clears phy interrupt unless a phy event comes in the same cycle
// - autoclear enable clear: phy interrupt pends until phy register access
// - pause advertise bit 16 loaded from eeprom at power-up
// - pause advertised only when full duplex is also advertised
// - select field 15-13 loaded from eeprom, sets negotiation default
// - even select values force speed and duplex with negotiation off
// - odd select values enable negotiation with listed advertised modes
// - external phy bit 12 enables mii and sets phy disable bit
// - phy disable bit 9 forces internal phy to low power
// - phy reset bit 10 holds phy in reset, no self clear
`ifndef PHY_CFG_DEFS_SVH
`define PHY_CFG_DEFS_SVH
`define CFG_OFFSET      12'h004
`define ISR_OFFSET      12'h010
`define BIT_ANEG_DONE   27
`define FLD_PHYCFG_LO   18
`define FLD_PHYCFG_HI   23
`define BIT_AUTOCLR     17
`define BIT_PAUSE       16
`define FLD_SEL_LO      13
`define FLD_SEL_HI      15
`define BIT_EXTPHY      12
`define BIT_PHYRST      10
`define BIT_PHYDIS      9
`define CFG_WMASK       32'h00FF_F600
`define CFG_RESET       32'h0000_0000
`endif

// ### rtl/phy_cfg_pkg.sv
package phy_cfg_pkg;
  typedef struct packed {
    logic       aneg_enable;
    logic       force_100;
    logic       force_full;
    logic [3:0] adv_modes;   // {100fd,100hd,10fd,10hd}
    logic       adv_pause;
  } phy_mode_s;
endpackage

// ### rtl/aneg_decode.sv
// Purpose: decode negotiation select into phy mode controls
// Assumes: purely combinational, registered by the caller
// Notes: none
`timescale 1ns/10ps
module aneg_decode
  import phy_cfg_pkg::*;
(
  input  wire logic [2:0] autoneg_select,
  input  wire logic       pause_advertise,
  output phy_mode_s       mode
);
  always_comb begin
    mode = '0;
    mode.aneg_enable = autoneg_select[0];
    if (!autoneg_select[0]) begin
      mode.force_100  = autoneg_select[1];
      mode.force_full = autoneg_select[2];
    end else begin
      case (autoneg_select[2:1])
        2'h0:    mode.adv_modes = 4'h3;
        2'h1:    mode.adv_modes = 4'h5;
        2'h2:    mode.adv_modes = 4'hC;
        default: mode.adv_modes = 4'hF;
      endcase
    end
    // pause only rides on a full duplex advertisement
    mode.adv_pause = pause_advertise & mode.aneg_enable
                     & (mode.adv_modes[1] | mode.adv_modes[3]);
  end
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for the config and media status register fields
// Assumes: zero wait state apb slave, eeprom load pulse drives bits 16 and 15-13
// Notes: pready, prdata and pslverr taken at the rising edge that ends the access
`timescale 1ns/10ps
`include "phy_cfg_defs.svh"
module testbench
  import phy_cfg_pkg::*;
;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, phy_irq_pending, phy_reset, phy_low_power, mii_enable;
  logic        phy_aneg_complete = 0, phy_irq_event = 0, phy_reg_access = 0;
  logic        ee_load_valid = 0, ee_pause = 0;
  logic [2:0]  ee_select = 3'h0;
  phy_mode_s   phy_mode;
  int          err_total = 0, n_compared = 0;
  logic [3:0]  adv [4] = '{4'h3, 4'h5, 4'hC, 4'hF};
  phy_config_media_fields i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phy_aneg_complete(phy_aneg_complete),
    .phy_irq_event(phy_irq_event), .phy_reg_access(phy_reg_access),
    .ee_load_valid(ee_load_valid), .ee_pause(ee_pause), .ee_select(ee_select),
    .phy_irq_pending(phy_irq_pending), .phy_reset(phy_reset),
    .phy_low_power(phy_low_power), .mii_enable(mii_enable), .phy_mode(phy_mode));
  initial begin
    forever #4 pclk = ~pclk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      err_total++;
      complete_run();
    end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic pulse_event(input logic acc);
    @(posedge pclk);
    if (acc) phy_reg_access <= 1; else phy_irq_event <= 1;
    @(posedge pclk);
    phy_reg_access <= 0; phy_irq_event <= 0;
    settle(2);
  endtask
  task automatic select_sweep();
    for (int s = 0; s < 8; s++) begin
      @(posedge pclk);
      ee_load_valid <= 1; ee_select <= 3'(s); ee_pause <= 1;
      @(posedge pclk);
      ee_load_valid <= 0;
      settle(6);
      chk("aneg_en", 32'(s & 1), 32'(phy_mode.aneg_enable));
      if (s % 2 == 0) begin
        chk("force", 32'(s >> 1), 32'({phy_mode.force_full, phy_mode.force_100}));
      end else begin
        chk("adv", 32'(adv[s >> 1]), 32'(phy_mode.adv_modes));
        chk("pause", 32'(s != 3), 32'(phy_mode.adv_pause));
      end
      apb(0, `CFG_OFFSET, 32'h0);
      chk("cfg_ee", (s % 2 ? 0 : 32'h0800_0000) | 32'h0001_0000 | 32'(s << 13), r);
    end
  endtask
  task automatic write_fields();
    apb(1, `CFG_OFFSET, 32'hFFFF_FFFF);
    settle(2);
    chk("ctl_out", 32'h7, 32'({phy_reset, phy_low_power, mii_enable}));
    apb(0, `CFG_OFFSET, 32'h0);
    chk("cfg_ones", 32'h00FF_F600, r);
    phy_aneg_complete <= 1;
    settle(5);
    apb(0, `CFG_OFFSET, 32'h0);
    chk("cfg_done", 32'h08FF_F600, r);
    apb(1, `CFG_OFFSET, 32'h0000_1000);
    settle(2);
    chk("ext_out", 32'h3, 32'({phy_reset, phy_low_power, mii_enable}));
    apb(0, `CFG_OFFSET, 32'h0);
    chk("cfg_ext", 32'h0800_1200, r);
  endtask
  task automatic irq_clear();
    apb(1, `CFG_OFFSET, 32'h0002_0000);
    pulse_event(0);
    chk("pend_set", 1, 32'(phy_irq_pending));
    apb(0, `ISR_OFFSET, 32'h0);
    settle(1);
    chk("pend_auto", 0, 32'(phy_irq_pending));
    apb(1, `CFG_OFFSET, 32'h0);
    pulse_event(0);
    apb(0, `ISR_OFFSET, 32'h0);
    settle(1);
    chk("pend_hold", 1, 32'(phy_irq_pending));
    pulse_event(1);
    chk("pend_phy", 0, 32'(phy_irq_pending));
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    settle(6);
    apb(0, `CFG_OFFSET, 32'h0);
    chk("cfg_rst", 32'h0800_0000, r);
    apb(0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, 32'({r, e}));
    select_sweep();
    write_fields();
    irq_clear();
    complete_run();
  end
endmodule
